// ---- hrsg_pkg.sv ----
// ============================================================
// Shared constants for the clock-memory host controller
package hrsg_pkg;
   localparam int ADDR_W = 15;                        // Address lines
   localparam int DATA_W = 8;
   localparam int SEQ_BITS = 64;                      // Unlock and transfer length
   localparam logic [63:0] UNLOCK_PAT = 64'h5CA33AC55CA33AC5; // Sent bit 0 first
   localparam logic [14:0] SCRATCH_ADDR_RST = 15'h7FFF;
   // Bus timing, in ns, and derived cycle counts at 100 MHz
   localparam int CLK_NS = 10;
   localparam int T_SETUP_NS = 20;                    // Address before strobe
   localparam int T_PULSE_NS = 70;                    // Strobe low time
   localparam int T_REC_NS = 20;                      // Write recovery time
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
   localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
   localparam logic [3:0] REC_CNT = 4'(REC_CYC);
   // One-hot bus cycle phases
   typedef enum logic [3:0] {
      HRSG_IDLE  = 4'h1,
      HRSG_SETUP = 4'h2,
      HRSG_PULSE = 4'h4,
      HRSG_REC   = 4'h8
   } hrsg_phase_t;
endpackage : hrsg_pkg

// ---- hrsg_cycle.sv ----
`timescale 1ns/10ps
// ============================================================
// One asynchronous memory bus cycle: setup, strobe, recovery
module hrsg_cycle
   import hrsg_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   // Request
   input  wire logic              start_i,
   input  wire logic              write_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [DATA_W-1:0]      rdata_o,
   // Pins
   output logic                   chip_sel_n_o,
   output logic                   out_drv_n_o,
   output logic                   wr_strobe_n_o,
   output logic [ADDR_W-1:0]      addr_lines_o,
   output logic [DATA_W-1:0]      data_o,
   output logic                   data_oe_o,
   input  wire logic [DATA_W-1:0] data_sync_i
);
   hrsg_phase_t       ph_r, ph_nxt;
   logic [3:0]        cnt_r, cnt_nxt;
   logic              wr_r, wr_nxt;
   logic [ADDR_W-1:0] a_r, a_nxt;
   logic [DATA_W-1:0] d_r, d_nxt, rd_r, rd_nxt;
   logic              done_r, done_nxt;

   // ============================================================
   // Cycle sequencer
   always_comb begin
      ph_nxt = ph_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      a_nxt = a_r;
      d_nxt = d_r;
      rd_nxt = rd_r;
      done_nxt = 1'b0;
      case (ph_r)
         HRSG_IDLE: begin
            if (start_i) begin
               ph_nxt = HRSG_SETUP;
               cnt_nxt = SETUP_CNT;
               wr_nxt = write_i;
               a_nxt = addr_i;                 // Held for whole cycle
               d_nxt = wdata_i;
            end
         end
         HRSG_SETUP: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               ph_nxt = HRSG_PULSE;
               cnt_nxt = PULSE_CNT;
            end
         end
         HRSG_PULSE: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               ph_nxt = HRSG_REC;
               cnt_nxt = REC_CNT;
               rd_nxt = data_sync_i;           // Sample before strobes rise
            end
         end
         HRSG_REC: begin
            // Strobes stay high for the recovery interval
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               ph_nxt = HRSG_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: ph_nxt = HRSG_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ph_r <= HRSG_IDLE;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         a_r <= '0;
         d_r <= '0;
         rd_r <= '0;
         done_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         rd_r <= rd_nxt;
         done_r <= done_nxt;
      end
   end

   // ============================================================
   // Pin registers; write cycles never assert output drive
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         chip_sel_n_o <= 1'b1;
         out_drv_n_o <= 1'b1;
         wr_strobe_n_o <= 1'b1;
         addr_lines_o <= '0;
         data_o <= '0;
         data_oe_o <= 1'b0;
      end else begin
         chip_sel_n_o <= ~(ph_nxt == HRSG_PULSE);
         out_drv_n_o <= ~(ph_nxt == HRSG_PULSE && !wr_nxt);
         wr_strobe_n_o <= ~(ph_nxt == HRSG_PULSE && wr_nxt);
         addr_lines_o <= a_nxt;
         data_o <= d_nxt;
         data_oe_o <= wr_nxt && (ph_nxt != HRSG_IDLE);
      end
   end

   assign busy_o = (ph_r != HRSG_IDLE);
   assign done_o = done_r;
   assign rdata_o = rd_r;
endmodule : hrsg_cycle

// ---- hrsg_host.sv ----
`timescale 1ns/10ps
// ============================================================
// Operation
// - Host holds address through write cycle
// - Host keeps strobe high for recovery
// - Host keeps output drive high writing
// - Unlock needs 64 matching writes
// - Host uses one scratch location
// - Pattern C5 3A A3 5C twice, LSB first
// - Eight BCD registers, bit 0 first
// ============================================================
// Host controller: runs whole-clock reads and writes, and plain memory access
module hrsg_host
   import hrsg_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   // Memory request
   input  wire logic              mem_req_i,
   input  wire logic              mem_write_i,
   input  wire logic [ADDR_W-1:0] mem_addr_i,
   input  wire logic [DATA_W-1:0] mem_wdata_i,
   // Clock request
   input  wire logic              clk_rd_req_i,
   input  wire logic              clk_wr_req_i,
   input  wire logic [63:0]       clk_wdata_i,
   input  wire logic [ADDR_W-1:0] scratch_addr_i,
   // Status
   input  wire logic              power_ok_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [DATA_W-1:0]      mem_rdata_o,
   output logic [63:0]            clk_rdata_o,
   // Device pins
   output logic                   chip_sel_n_o,
   output logic                   out_drv_n_o,
   output logic                   wr_strobe_n_o,
   output logic [ADDR_W-1:0]      addr_lines_o,
   output logic [DATA_W-1:0]      data_o,
   output logic                   data_oe_o,
   input  wire logic [DATA_W-1:0] data_i
);
   typedef enum logic [4:0] {
      HRSG_S_IDLE  = 5'h01,
      HRSG_S_MEM   = 5'h02,
      HRSG_S_SYNC  = 5'h04,
      HRSG_S_KEY   = 5'h08,
      HRSG_S_XFER  = 5'h10
   } hrsg_state_t;

   hrsg_state_t       st_r, st_nxt;
   logic [6:0]        idx_r, idx_nxt;
   logic              wr_r, wr_nxt;
   logic [63:0]       tx_r, tx_nxt, rx_r, rx_nxt;
   logic              busy_r, busy_nxt, done_r, done_nxt;
   logic [DATA_W-1:0] mrd_r, mrd_nxt;
   logic [ADDR_W-1:0] scr_r, scr_nxt;
   logic              pok_r, pok_nxt;
   logic              start;
   logic              cyc_wr;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   logic              cyc_busy, cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   logic [DATA_W-1:0] d_s1_r, d_s2_r, d_s3_r, d_stab_r;
   logic              p_s1_r, p_s2_r, p_s3_r;

   // ============================================================
   // Pin inputs: three stages, a change counts when stages two and three agree
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         d_s1_r <= '0;
         d_s2_r <= '0;
         d_s3_r <= '0;
         d_stab_r <= '0;
         p_s1_r <= 1'b0;
         p_s2_r <= 1'b0;
         p_s3_r <= 1'b0;
         pok_r <= 1'b0;
      end else begin
         d_s1_r <= data_i;
         d_s2_r <= d_s1_r;
         d_s3_r <= d_s2_r;
         p_s1_r <= power_ok_i;
         p_s2_r <= p_s1_r;
         p_s3_r <= p_s2_r;
         pok_r <= pok_nxt;
         for (int i = 0; i < DATA_W; i++) begin
            if (d_s2_r[i] == d_s3_r[i]) begin
               d_stab_r[i] <= d_s3_r[i];
            end
         end
      end
   end
   assign pok_nxt = (p_s2_r == p_s3_r) ? p_s3_r : pok_r;

   // ============================================================
   // Sequencer: sync read, 64 key writes, 64 transfer cycles
   always_comb begin
      st_nxt = st_r;
      idx_nxt = idx_r;
      wr_nxt = wr_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      mrd_nxt = mrd_r;
      scr_nxt = scr_r;
      case (st_r)
         HRSG_S_IDLE: begin
            // Device rejects all access below the threshold, so hold off
            if (pok_r && (clk_rd_req_i || clk_wr_req_i)) begin
               st_nxt = HRSG_S_SYNC;
               wr_nxt = clk_wr_req_i && !clk_rd_req_i;
               tx_nxt = clk_wdata_i;
               scr_nxt = scratch_addr_i;       // Single scratch location
               busy_nxt = 1'b1;
            end else if (pok_r && mem_req_i) begin
               st_nxt = HRSG_S_MEM;            // Plain memory access
               busy_nxt = 1'b1;
            end
         end
         HRSG_S_MEM: begin
            if (cyc_done) begin
               mrd_nxt = cyc_rdata;
               st_nxt = HRSG_S_IDLE;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
            end
         end
         HRSG_S_SYNC: begin
            // A read first resets the device's comparison pointer
            if (cyc_done) begin
               st_nxt = HRSG_S_KEY;
               idx_nxt = 7'h00;
            end
         end
         HRSG_S_KEY: begin
            // Key bits go out bit 0 first, writes only
            if (cyc_done) begin
               idx_nxt = idx_r + 7'h01;
               if (idx_r == 7'(SEQ_BITS - 1)) begin
                  st_nxt = HRSG_S_XFER;
                  idx_nxt = 7'h00;
               end
            end
         end
         HRSG_S_XFER: begin
            // 64 cycles, register 0 bit 0 through register 7 bit 7
            if (cyc_done) begin
               rx_nxt = {cyc_rdata[0], rx_r[63:1]};  // Clock bit on line zero
               tx_nxt = {1'b0, tx_r[63:1]};
               idx_nxt = idx_r + 7'h01;
               if (idx_r == 7'(SEQ_BITS - 1)) begin
                  st_nxt = HRSG_S_IDLE;        // Device back in memory mode
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
         end
         default: st_nxt = HRSG_S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r <= HRSG_S_IDLE;
         idx_r <= 7'h00;
         wr_r <= 1'b0;
         tx_r <= '0;
         rx_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         mrd_r <= '0;
         scr_r <= SCRATCH_ADDR_RST;
      end else begin
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         wr_r <= wr_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         mrd_r <= mrd_nxt;
         scr_r <= scr_nxt;
      end
   end

   // ============================================================
   // Cycle request: key writes also land in the scratch byte
   always_comb begin
      start = 1'b0;
      cyc_wr = 1'b0;
      cyc_addr = scr_r;
      cyc_data = '0;
      if (!cyc_busy && !cyc_done) begin
         case (st_r)
            HRSG_S_MEM: begin
               start = 1'b1;
               cyc_wr = mem_write_i;
               cyc_addr = mem_addr_i;
               cyc_data = mem_wdata_i;
            end
            HRSG_S_SYNC: start = 1'b1;
            HRSG_S_KEY: begin
               start = 1'b1;
               cyc_wr = 1'b1;
               cyc_data = {7'h00, UNLOCK_PAT[idx_r[5:0]]};
            end
            HRSG_S_XFER: begin
               start = 1'b1;
               cyc_wr = wr_r;
               cyc_data = {7'h00, tx_r[0]};
            end
            default: start = 1'b0;
         endcase
      end
   end

   hrsg_cycle u_cycle (
      .clk_i         (clk_i),
      .srst_i        (srst_i),
      .start_i       (start),
      .write_i       (cyc_wr),
      .addr_i        (cyc_addr),
      .wdata_i       (cyc_data),
      .busy_o        (cyc_busy),
      .done_o        (cyc_done),
      .rdata_o       (cyc_rdata),
      .chip_sel_n_o  (chip_sel_n_o),
      .out_drv_n_o   (out_drv_n_o),
      .wr_strobe_n_o (wr_strobe_n_o),
      .addr_lines_o  (addr_lines_o),
      .data_o        (data_o),
      .data_oe_o     (data_oe_o),
      .data_sync_i   (d_stab_r)
   );

   // Status outputs straight from registers
   assign busy_o = busy_r;
   assign done_o = done_r;
   assign mem_rdata_o = mrd_r;
   assign clk_rdata_o = rx_r;
endmodule : hrsg_host

// ---- hrsg_monitor.sv ----
`timescale 1ns/10ps
// ============================================================
// Pin timing checks on the host side of the memory bus
module hrsg_monitor
   import hrsg_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   // Status and pins
   input  wire logic              power_ok_i,
   input  wire logic              busy_o,
   input  wire logic              chip_sel_n_o,
   input  wire logic              out_drv_n_o,
   input  wire logic              wr_strobe_n_o,
   input  wire logic [ADDR_W-1:0] addr_lines_o,
   input  wire logic              data_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // Address must settle before select falls
   addr_setup_a: assert property ($fell(chip_sel_n_o) |-> $stable(addr_lines_o))
      else $error("address moved as select fell");
   // Address frozen while the write strobe is low
   addr_hold_a: assert property (
      !wr_strobe_n_o && !$past(wr_strobe_n_o) |-> $stable(addr_lines_o))
      else $error("address moved inside a write");
   // Write strobe low for the whole pulse, then both strobes rise together
   wr_pulse_a: assert property (
      $fell(wr_strobe_n_o) |-> (!wr_strobe_n_o && !chip_sel_n_o)[*7]
      ##1 (wr_strobe_n_o && chip_sel_n_o))
      else $error("write pulse shape wrong");
   // Read pulse keeps the write strobe high
   rd_pulse_a: assert property (
      $fell(out_drv_n_o) |->
      (!out_drv_n_o && !chip_sel_n_o && wr_strobe_n_o)[*7] ##1 out_drv_n_o)
      else $error("read pulse shape wrong");
   // Recovery: strobe and select stay high after a write
   wr_recovery_a: assert property (
      $rose(wr_strobe_n_o) |-> (wr_strobe_n_o && chip_sel_n_o)[*2])
      else $error("write recovery too short");
   // Output drive kept off while the host drives data, avoiding contention
   bus_turn_a: assert property (data_oe_o |-> out_drv_n_o)
      else $error("output drive low while host drives data");
   // Data driven throughout the write strobe
   wr_data_a: assert property (!wr_strobe_n_o |-> data_oe_o)
      else $error("write strobe without data drive");
   // No request taken unless power was seen good shortly before
   power_gate_a: assert property (
      $rose(busy_o) |->
      ($past(power_ok_i, 3) || $past(power_ok_i, 4) || $past(power_ok_i, 5)))
      else $error("request taken while power low");
endmodule : hrsg_monitor

bind hrsg_host hrsg_monitor hrsg_monitor_i (
   .clk_i        (clk_i),
   .srst_i       (srst_i),
   .power_ok_i   (power_ok_i),
   .busy_o       (busy_o),
   .chip_sel_n_o (chip_sel_n_o),
   .out_drv_n_o  (out_drv_n_o),
   .wr_strobe_n_o(wr_strobe_n_o),
   .addr_lines_o (addr_lines_o),
   .data_oe_o    (data_oe_o)
);

// ---- hrsg_dev_model.sv ----
`timescale 1ns/10ps
// ============================================================
// Behavioural memory with a concealed clock, worked by pin edges
module hrsg_dev_model
   import hrsg_pkg::*;
#(
   parameter logic [63:0] TK_INIT = 64'h2406155930120000 // Arbitrary start time
)(
   // Host pins
   input  wire logic              ce_n_i,
   input  wire logic              oe_n_i,
   input  wire logic              we_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] host_data_i,
   input  wire logic              host_oe_i,
   input  wire logic              power_ok_i,
   // Resolved data bus
   output logic [DATA_W-1:0]      bus_o
);
   logic [DATA_W-1:0] mem [0:32767];
   logic [63:0]       tk_r    = TK_INIT;
   logic [6:0]        ptr_r   = 7'h00;
   logic [6:0]        xfer_r  = 7'h00;
   logic              armed_r = 1'b0;
   logic              open_r  = 1'b0;
   logic              wr_seen = 1'b0;
   logic              rd_seen = 1'b0;
   logic [ADDR_W-1:0] a_q     = 15'h0000;
   logic [DATA_W-1:0] d_q     = 8'h00;
   logic [DATA_W-1:0] idle_r  = 8'h5A;
   // Released bus wanders so a stale value never passes for data
   always #7 idle_r = ~idle_r;
   // Drive only with select and output drive low and the write strobe high
   assign bus_o = host_oe_i ? host_data_i :
                  (!ce_n_i && !oe_n_i && we_n_i && power_ok_i) ?
                  (open_r ? {7'h00, tk_r[xfer_r[5:0]]} : mem[addr_i]) : idle_r;
   // Classify the cycle once the strobes have settled
   always @(negedge ce_n_i) begin
      #1;
      wr_seen = !we_n_i;
      rd_seen = !oe_n_i && we_n_i;
      a_q = addr_i;
      d_q = host_data_i;
   end
   // Each finished cycle steps the transfer or the recogniser; only this
   // chip's select edges count, so cycles to other chips leave progress alone
   always @(posedge ce_n_i) begin
      if (power_ok_i && open_r) begin
         if (wr_seen) tk_r[xfer_r[5:0]] = d_q[0];
         xfer_r = xfer_r + 7'h01;
         if (xfer_r == 7'h40) begin
            open_r = 1'b0;
            armed_r = 1'b0;
         end
      end else if (power_ok_i && rd_seen) begin
         ptr_r = 7'h00;
         armed_r = 1'b1;
      end else if (power_ok_i && wr_seen) begin
         mem[a_q] = d_q;
         if (armed_r && d_q[0] == UNLOCK_PAT[ptr_r[5:0]]) ptr_r = ptr_r + 7'h01;
         else armed_r = 1'b0;
         if (ptr_r == 7'h40) begin
            open_r = 1'b1;
            xfer_r = 7'h00;
            ptr_r = 7'h00;
         end
      end
   end
endmodule : hrsg_dev_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
// ============================================================
// Host controller bench against the behavioural device
module tb_top;
   import hrsg_pkg::*;
   localparam logic [63:0] TK_INIT = 64'h2406155930120000;
   localparam logic [63:0] TK_NEW  = 64'h8112300745592199;
   logic              clk_i = 1'b0, srst_i = 1'b1, power_ok_i = 1'b1;
   logic              mem_req_i = 1'b0, mem_write_i = 1'b0;
   logic              clk_rd_req_i = 1'b0, clk_wr_req_i = 1'b0;
   logic [ADDR_W-1:0] mem_addr_i = 15'h0000, scratch_addr_i = 15'h0100;
   logic [DATA_W-1:0] mem_wdata_i = 8'h00, data_i;
   logic [63:0]       clk_wdata_i = 64'h0, clk_rdata_o;
   logic              busy_o, done_o, chip_sel_n_o, out_drv_n_o, wr_strobe_n_o, data_oe_o;
   logic [ADDR_W-1:0] addr_lines_o;
   logic [DATA_W-1:0] mem_rdata_o, data_o;
   int                err_total = 0, cmp_count = 0, cyc = 0;
   always #5 clk_i = ~clk_i;
   hrsg_host hrsg_host_i (.clk_i(clk_i), .srst_i(srst_i), .mem_req_i(mem_req_i),
      .mem_write_i(mem_write_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
      .clk_rd_req_i(clk_rd_req_i), .clk_wr_req_i(clk_wr_req_i), .clk_wdata_i(clk_wdata_i),
      .scratch_addr_i(scratch_addr_i), .power_ok_i(power_ok_i), .busy_o(busy_o),
      .done_o(done_o), .mem_rdata_o(mem_rdata_o), .clk_rdata_o(clk_rdata_o),
      .chip_sel_n_o(chip_sel_n_o), .out_drv_n_o(out_drv_n_o), .wr_strobe_n_o(wr_strobe_n_o),
      .addr_lines_o(addr_lines_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i));
   hrsg_dev_model #(.TK_INIT(TK_INIT)) hrsg_dev_model_i (.ce_n_i(chip_sel_n_o),
      .oe_n_i(out_drv_n_o), .we_n_i(wr_strobe_n_o), .addr_i(addr_lines_o),
      .host_data_i(data_o), .host_oe_i(data_oe_o), .power_ok_i(power_ok_i), .bus_o(data_i));
   // ============================================================
   // Shared tasks
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   // Request is dropped once taken, so the idle state cannot take it twice
   task automatic finish_req();
      int n;
      n = 0;
      do begin @(negedge clk_i); n++; end while (busy_o !== 1'b1 && n < 20);
      @(posedge clk_i);
      mem_req_i <= 1'b0;
      clk_rd_req_i <= 1'b0;
      clk_wr_req_i <= 1'b0;
      do begin @(negedge clk_i); n++; end while (done_o !== 1'b1 && n < 3000);
      check("done_o", 1, done_o);
      @(posedge clk_i);
   endtask : finish_req
   task automatic mem_acc(input logic wr, input logic [14:0] a, input logic [7:0] d);
      @(posedge clk_i);
      mem_req_i <= 1'b1;
      mem_write_i <= wr;
      mem_addr_i <= a;
      mem_wdata_i <= d;
      finish_req();
   endtask : mem_acc
   task automatic clk_acc(input logic rd, input logic wr, input logic [63:0] d);
      @(posedge clk_i);
      clk_rd_req_i <= rd;
      clk_wr_req_i <= wr;
      clk_wdata_i <= d;
      finish_req();
   endtask : clk_acc
   // ============================================================
   // Scenarios
   task automatic test_mem();
      mem_acc(1'b1, 15'h1234, 8'hC3);
      mem_acc(1'b1, 15'h7FFF, 8'h3C);
      mem_acc(1'b0, 15'h1234, 8'h00);
      check("mem_rdata_o", 8'hC3, mem_rdata_o);
      mem_acc(1'b0, 15'h7FFF, 8'h00);
      check("mem_rdata_o", 8'h3C, mem_rdata_o);
      $display("memory test done");
   endtask : test_mem
   task automatic test_clk_read();
      clk_acc(1'b1, 1'b0, 64'h0);
      check("clk_rdata_o", TK_INIT, clk_rdata_o);
      mem_acc(1'b0, 15'h0100, 8'h00);
      check("scratch byte", {7'h00, UNLOCK_PAT[63]}, mem_rdata_o);
      $display("clock read test done");
   endtask : test_clk_read
   task automatic test_clk_write();
      clk_acc(1'b0, 1'b1, TK_NEW);
      // Transfer writes must not land in memory, so the last key bit stays
      mem_acc(1'b0, 15'h0100, 8'h00);
      check("scratch byte", {7'h00, UNLOCK_PAT[63]}, mem_rdata_o);
      // Both requests together: the read wins and the clock keeps what was written
      clk_acc(1'b1, 1'b1, ~TK_NEW);
      check("clk_rdata_o", TK_NEW, clk_rdata_o);
      mem_acc(1'b0, 15'h1234, 8'h00);
      check("mem_rdata_o", 8'hC3, mem_rdata_o);
      $display("clock write test done");
   endtask : test_clk_write
   task automatic test_power();
      @(posedge clk_i);
      power_ok_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      mem_req_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      check("busy_o", 0, busy_o);
      mem_req_i <= 1'b0;
      power_ok_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      mem_acc(1'b0, 15'h7FFF, 8'h00);
      check("mem_rdata_o", 8'h3C, mem_rdata_o);
      $display("power test done");
   endtask : test_power
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   // Hang guard: a full run needs well under this many cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("unexpected timeout: expected end, seen cycle %0d", cyc);
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      test_mem();
      test_clk_read();
      test_clk_write();
      test_power();
      give_verdict();
   end
endmodule : tb_top
